// [udp_port_window_filter_defs.vh]
// constants for the udp port window input filter
// assumes a 20 MHz system clock and a byte-wide ethernet frame stream
`ifndef UDP_PORT_WINDOW_FILTER_DEFS_VH
`define UDP_PORT_WINDOW_FILTER_DEFS_VH

// ==========================================================
// window and timing
`define PORT_WIDTH        16
`define WINDOW_SIZE       16'h0800
`define DECIDE_TIME_NS    100
`define CLK_PERIOD_NS     50
`define DECIDE_CYCLES     (`DECIDE_TIME_NS / `CLK_PERIOD_NS)
`define SELECTOR_COUNT    4
`define STREAM_TABLE_SIZE 256
`define RATE_WINDOW_CYC   20000

// ==========================================================
// frame byte offsets (ethernet + ipv4 without options)
`define OFF_ETYPE_HI      14'd12
`define OFF_ETYPE_LO      14'd13
`define OFF_ARP_OPER_LO   14'd21
`define OFF_IP_PROTO      14'd23
`define OFF_DPORT_HI      14'd36
`define OFF_DPORT_LO      14'd37
`define OFF_IGMP_TYPE     14'd34
`define ETYPE_IP_HI       8'h08
`define ETYPE_IP_LO       8'h00
`define ETYPE_ARP_LO      8'h06
`define PROTO_UDP         8'h11
`define PROTO_IGMP        8'h02
`define IGMP_QUERY        8'h11

// ==========================================================
// igmp action codes
`define IGMP_REPORT       2'h1
`define IGMP_LEAVE        2'h2

`endif

// [udp_port_window_filter.v]
// udp port window input filter with arp/igmp control event generation
// assumes frames arrive one byte per cycle, synchronous to clk; packet formatting of arp/igmp replies is downstream
`timescale 1ns/1ps
`include "udp_port_window_filter_defs.vh"

// Operation
// - accept udp packet only when port lies in base to base plus 2047
// - decide pass or discard within 100 ns of the port arriving
// - forward accepted packets to selectors, drop rejected packets; live bytes arriving during the 38-cycle header drain are dropped
// - one filter and one window base shared by four selectors
// - port numbers are 16-bit unsigned, 0 to 65535
// - answer every arriving arp request automatically
// - request by igmp exactly the multicast streams in the table
// - keep a 256-entry table of address and port; only its multicast addresses are used, for igmp
// - measure aggregate rate of accepted bytes for diagnostics
// - report on start, leave on end, answer membership queries
// - never check destination ip or mac; port alone selects
module udp_port_window_filter #(
  parameter TABLE_DEPTH = `STREAM_TABLE_SIZE,
  parameter RATE_WINDOW = `RATE_WINDOW_CYC
) (
  // clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // shared window base and table programming
  input  wire [15:0] windowBase,
  input  wire        tableWrite,
  input  wire [7:0]  tableIndex,
  input  wire [31:0] tableAddr,
  input  wire [15:0] tablePort,
  input  wire        tableValid,
  // incoming frame stream
  input  wire [7:0]  rxData,
  input  wire        rxValid,
  input  wire        rxLast,
  // forwarded stream to the four selectors
  output reg  [7:0]  selData,
  output reg  [3:0]  selValid,
  output reg         selLast,
  // decision and control events
  output reg         decideValid,
  output reg         decidePass,
  output reg         arpReply,
  output reg  [1:0]  igmpAction,
  output reg  [31:0] igmpGroup,
  output reg         igmpSend,
  // diagnostics
  output reg  [31:0] passRate
);

  // ==========================================================
  // reset release
  reg rstMeta_reg;
  reg rstSync_reg;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  wire rstN = rstSync_reg;

  function inWindow;
    input [15:0] port;
    input [15:0] base;
    reg   [15:0] diff;
    begin
      diff = port - base;
      inWindow = (diff < `WINDOW_SIZE);
    end
  endfunction

  // ==========================================================
  // input stream table
  reg [31:0] tblAddr [0:TABLE_DEPTH-1];
  reg [15:0] tblPort [0:TABLE_DEPTH-1];
  reg        tblValid_reg [0:TABLE_DEPTH-1];
  always @(posedge clk) begin
    if (tableWrite) begin
      tblAddr[tableIndex] <= tableAddr;
      tblPort[tableIndex] <= tablePort;
    end
  end
  integer i;
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (i = 0; i < TABLE_DEPTH; i = i + 1)
        tblValid_reg[i] <= 1'b0;
    end else if (tableWrite) begin
      tblValid_reg[tableIndex] <= tableValid;
    end
  end

  // ==========================================================
  // header parse; destination addresses deliberately ignored
  reg  [13:0] byteCnt_reg;
  reg  [7:0]  etypeHi_reg;
  reg         isIp_reg;
  reg         isArp_reg;
  reg         isUdp_reg;
  reg         isIgmp_reg;
  reg  [7:0]  portHi_reg;
  reg         decided_reg;
  reg         pass_reg;
  // frame bytes held until decided; port is byte 37 so the hold is fixed
  reg  [7:0]  holdMem [0:37];
  wire [13:0] byteCnt_next = rxLast ? 14'd0 : byteCnt_reg + 14'd1;
  wire        portDone = rxValid && byteCnt_reg == `OFF_DPORT_LO && isUdp_reg;
  wire        portPass = inWindow({portHi_reg, rxData}, windowBase);

  always @(posedge clk) begin
    if (rxValid && byteCnt_reg <= `OFF_DPORT_LO)
      holdMem[byteCnt_reg[5:0]] <= rxData;
  end

  reg [5:0] drainCnt_reg;
  reg       draining_reg;
  // frame ended on the last port byte, so its end marker rides the drain
  reg       endHeld_reg;

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      byteCnt_reg  <= 14'd0;
      etypeHi_reg  <= 8'h00;
      isIp_reg     <= 1'b0;
      isArp_reg    <= 1'b0;
      isUdp_reg    <= 1'b0;
      isIgmp_reg   <= 1'b0;
      portHi_reg   <= 8'h00;
      decided_reg  <= 1'b0;
      pass_reg     <= 1'b0;
      decideValid  <= 1'b0;
      decidePass   <= 1'b0;
      arpReply     <= 1'b0;
      selData      <= 8'h00;
      selValid     <= 4'h0;
      selLast      <= 1'b0;
      drainCnt_reg <= 6'h00;
      draining_reg <= 1'b0;
      endHeld_reg  <= 1'b0;
    end else begin
      decideValid <= 1'b0;
      arpReply    <= 1'b0;
      selValid    <= 4'h0;
      selLast     <= 1'b0;
      if (rxValid) begin
        byteCnt_reg <= byteCnt_next;
        if (byteCnt_reg == `OFF_ETYPE_HI)
          etypeHi_reg <= rxData;
        if (byteCnt_reg == `OFF_ETYPE_LO) begin
          isIp_reg  <= etypeHi_reg == `ETYPE_IP_HI && rxData == `ETYPE_IP_LO;
          isArp_reg <= etypeHi_reg == `ETYPE_IP_HI && rxData == `ETYPE_ARP_LO;
        end
        if (byteCnt_reg == `OFF_IP_PROTO) begin
          isUdp_reg  <= isIp_reg && rxData == `PROTO_UDP;
          isIgmp_reg <= isIp_reg && rxData == `PROTO_IGMP;
        end
        // arp request: oper low byte = 1
        if (byteCnt_reg == `OFF_ARP_OPER_LO && isArp_reg && rxData == 8'h01)
          arpReply <= 1'b1;
        if (byteCnt_reg == `OFF_DPORT_HI)
          portHi_reg <= rxData;
        // decided the cycle the last port byte arrives: within 100 ns
        if (portDone) begin
          decided_reg  <= 1'b1;
          pass_reg     <= portPass;
          decideValid  <= 1'b1;
          decidePass   <= portPass;
          draining_reg <= portPass;
          drainCnt_reg <= 6'h00;
          endHeld_reg  <= rxLast;
        end
        if (rxLast) begin
          decided_reg <= 1'b0;
          pass_reg    <= 1'b0;
          isUdp_reg   <= 1'b0;
          isIp_reg    <= 1'b0;
          isArp_reg   <= 1'b0;
          isIgmp_reg  <= 1'b0;
        end
      end
      // held header drains first, then live bytes; live bytes arriving
      // during the drain are dropped, since only the held header is forwarded then
      if (draining_reg) begin
        selData      <= holdMem[drainCnt_reg];
        selValid     <= {`SELECTOR_COUNT{1'b1}};
        drainCnt_reg <= drainCnt_reg + 6'h01;
        if (drainCnt_reg == 6'd37) begin
          draining_reg <= 1'b0;
          selLast      <= endHeld_reg;
        end
      end else if (rxValid && decided_reg && pass_reg) begin
        selData  <= rxData;
        selValid <= {`SELECTOR_COUNT{1'b1}};
        selLast  <= rxLast;
      end
    end
  end

  // ==========================================================
  // igmp: report on entry enable, leave on disable, reports on query
  reg [7:0] scanIdx_reg;
  reg       scanBusy_reg;
  // joined state and group as the network last heard them
  reg       lastValid_reg [0:TABLE_DEPTH-1];
  reg [31:0] lastGroup [0:TABLE_DEPTH-1];
  wire      queryHit = rxValid && isIgmp_reg && byteCnt_reg == `OFF_IGMP_TYPE && rxData == `IGMP_QUERY;
  wire      curValid = tblValid_reg[scanIdx_reg];
  wire      wasValid = lastValid_reg[scanIdx_reg];
  wire      isMcast  = tblAddr[scanIdx_reg][31:28] == 4'he;
  wire      joinNow  = curValid && isMcast;
  wire      joinNew  = joinNow && !wasValid;
  // joined entry rewritten to another group: leave the old group first,
  // the new one is reported on the next visit of that entry
  wire      moved    = wasValid && tblAddr[scanIdx_reg] != lastGroup[scanIdx_reg];
  reg       queryPend_reg;
  integer   j;
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      scanIdx_reg   <= 8'h00;
      scanBusy_reg  <= 1'b0;
      queryPend_reg <= 1'b0;
      igmpSend      <= 1'b0;
      igmpAction    <= 2'h0;
      igmpGroup     <= 32'h0000_0000;
      for (j = 0; j < TABLE_DEPTH; j = j + 1)
        lastValid_reg[j] <= 1'b0;
    end else begin
      igmpSend <= 1'b0;
      if (queryHit)
        queryPend_reg <= 1'b1;
      if (wasValid && (!joinNow || moved)) begin
        igmpSend   <= 1'b1;
        igmpAction <= `IGMP_LEAVE;
        igmpGroup  <= lastGroup[scanIdx_reg];
        lastValid_reg[scanIdx_reg] <= 1'b0;
      end else if (joinNew) begin
        igmpSend   <= 1'b1;
        igmpAction <= `IGMP_REPORT;
        igmpGroup  <= tblAddr[scanIdx_reg];
        lastValid_reg[scanIdx_reg] <= 1'b1;
      end else if (scanBusy_reg && joinNow) begin
        igmpSend   <= 1'b1;
        igmpAction <= `IGMP_REPORT;
        igmpGroup  <= tblAddr[scanIdx_reg];
      end
      scanIdx_reg <= scanIdx_reg + 8'h01;
      if (scanIdx_reg == 8'hff) begin
        scanBusy_reg  <= queryPend_reg && !queryHit;
        queryPend_reg <= queryHit;
      end
    end
  end

  always @(posedge clk) begin
    if (rstN && joinNew)
      lastGroup[scanIdx_reg] <= tblAddr[scanIdx_reg];
  end

  // ==========================================================
  // accepted-byte rate per window, for diagnostics
  reg [31:0] rateCnt_reg;
  reg [31:0] rateTick_reg;
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rateCnt_reg  <= 32'h0000_0000;
      rateTick_reg <= 32'h0000_0000;
      passRate     <= 32'h0000_0000;
    end else begin
      if (rateTick_reg == RATE_WINDOW - 1) begin
        rateTick_reg <= 32'h0000_0000;
        passRate     <= rateCnt_reg + {31'h0, selValid[0]};
        rateCnt_reg  <= 32'h0000_0000;
      end else begin
        rateTick_reg <= rateTick_reg + 32'h0000_0001;
        rateCnt_reg  <= rateCnt_reg + {31'h0, selValid[0]};
      end
    end
  end

endmodule // udp_port_window_filter

// [udp_port_window_filter_asserts.sv]
// checker on the port window filter ports
// assumes ipv4 headers without options
`timescale 1ns/1ps
module udp_port_window_filter_asserts (
  // clock and reset
  input wire        clk,
  input wire        arst_n,
  // frame side
  input wire [15:0] windowBase,
  input wire [7:0]  rxData,
  input wire        rxValid,
  input wire        rxLast,
  // selector and event side
  input wire [3:0]  selValid,
  input wire        selLast,
  input wire        decideValid,
  input wire        decidePass,
  input wire        arpReply,
  input wire [1:0]  igmpAction,
  input wire [31:0] igmpGroup,
  input wire        igmpSend
);
  // ==========
  // frame byte tracking
  reg  [5:0]  cnt;
  reg  [7:0]  etHi, etLo, proto, portHi;
  wire [15:0] dif = {portHi, rxData} - windowBase;
  wire        udp = etHi == 8'h08 && etLo == 8'h00 && proto == 8'h11;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 6'h00;
    end else if (rxValid) begin
      cnt <= rxLast ? 6'h00 : cnt + 6'h01;
      if (cnt == 6'd12) etHi <= rxData;
      if (cnt == 6'd13) etLo <= rxData;
      if (cnt == 6'd23) proto <= rxData;
      if (cnt == 6'd36) portHi <= rxData;
    end
  end
  // ==========
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_drop; (selValid == 4'h0) [*8]; endsequence
  sequence s_fwd; (selValid == 4'hf) [*8]; endsequence
  property p_win;
    rxValid && cnt == 6'd37 && udp |=> decideValid && decidePass == $past(dif < 16'h0800);
  endproperty
  property p_dec; decideValid |-> $past(rxValid && cnt == 6'd37); endproperty
  property p_drop; decideValid && !decidePass |=> s_drop; endproperty
  property p_fwd; decideValid && decidePass |=> s_fwd; endproperty
  property p_all4; selValid == 4'h0 || selValid == 4'hf; endproperty
  property p_last; selLast |-> selValid == 4'hf; endproperty
  property p_arp;
    rxValid && cnt == 6'd21 && etHi == 8'h08 && etLo == 8'h06 && rxData == 8'h01 |=> arpReply;
  endproperty
  property p_igmp;
    igmpSend |-> igmpGroup[31:28] == 4'he && (igmpAction == 2'h1 || igmpAction == 2'h2);
  endproperty
  a_win: assert property (p_win) else $error("window decision wrong");
  a_dec: assert property (p_dec) else $error("decision at wrong byte");
  a_drop: assert property (p_drop) else $error("rejected frame forwarded");
  a_fwd: assert property (p_fwd) else $error("accepted frame not forwarded");
  a_all4: assert property (p_all4) else $error("selectors not fed together");
  a_last: assert property (p_last) else $error("last without valid");
  a_arp: assert property (p_arp) else $error("arp request unanswered");
  a_igmp: assert property (p_igmp) else $error("bad igmp event");
endmodule // udp_port_window_filter_asserts

bind udp_port_window_filter udp_port_window_filter_asserts i_udp_port_window_filter_asserts (
  .clk(clk), .arst_n(arst_n), .windowBase(windowBase), .rxData(rxData), .rxValid(rxValid),
  .rxLast(rxLast), .selValid(selValid), .selLast(selLast), .decideValid(decideValid),
  .decidePass(decidePass), .arpReply(arpReply), .igmpAction(igmpAction),
  .igmpGroup(igmpGroup), .igmpSend(igmpSend));

// [net_switch_model.sv]
// network switch model delivering byte-wide frames
// assumes calls start 1 ns after a rising clock edge
`timescale 1ns/1ps
module net_switch_model (
  // clock
  input wire       clk,
  // frame stream
  output reg [7:0] rxData,
  output reg       rxValid,
  output reg       rxLast
);
  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
    rxLast = 1'b0;
  end
  task send(input [5:0] len, input [15:0] et, input [7:0] pr, input [15:0] pt, input [7:0] b21,
            input [7:0] b34);
    integer i;
    begin
      for (i = 0; i < len; i = i + 1) begin
        // header drain gap, idle data keeps changing
        if (i == 38) repeat (40) begin
          rxValid = 1'b0;
          rxData = ~rxData;
          @(posedge clk);
          #1;
        end
        case (i)
          12: rxData = et[15:8];
          13: rxData = et[7:0];
          21: rxData = b21;
          23: rxData = pr;
          34: rxData = b34;
          36: rxData = pt[15:8];
          37: rxData = pt[7:0];
          default: rxData = i[7:0] ^ 8'h5a; // addresses arbitrary
        endcase
        rxValid = 1'b1;
        rxLast = (i == len - 1);
        @(posedge clk);
        #1;
      end
      rxValid = 1'b0;
      rxLast = 1'b0;
      rxData = ~rxData;
    end
  endtask
endmodule // net_switch_model

// [testbench.sv]
// self-checking bench for the port window filter
// assumes the switch model drives the frame stream
`timescale 1ns/1ps
module testbench;
  reg         clk = 1'b0, arst_n = 1'b0, tableWrite = 1'b0, tableValid = 1'b0;
  reg  [15:0] windowBase = 16'h0000, tablePort = 16'h0000;
  reg  [7:0]  tableIndex = 8'h00;
  reg  [31:0] tableAddr = 32'h0, seed = 32'h3263, grp, rmax, rnd;
  reg  [15:0] fEt, fPt;
  reg  [7:0]  fPr, fB21;
  reg  [1:0]  act;
  wire [7:0]  rxData, selData;
  wire        rxValid, rxLast, selLast, decideValid, decidePass, arpReply, igmpSend;
  wire [3:0]  selValid;
  wire [1:0]  igmpAction;
  wire [31:0] igmpGroup, passRate;
  integer     mismatches = 0, n_compared = 0, fwd, lasts, arps, igs, k;
  always #25 clk = ~clk;
  net_switch_model i_net_switch_model (.clk(clk), .rxData(rxData), .rxValid(rxValid), .rxLast(rxLast));
  udp_port_window_filter #(.TABLE_DEPTH(256), .RATE_WINDOW(16)) i_udp_port_window_filter (
    .clk(clk), .arst_n(arst_n), .windowBase(windowBase), .tableWrite(tableWrite),
    .tableIndex(tableIndex), .tableAddr(tableAddr), .tablePort(tablePort), .tableValid(tableValid),
    .rxData(rxData), .rxValid(rxValid), .rxLast(rxLast), .selData(selData), .selValid(selValid),
    .selLast(selLast), .decideValid(decideValid), .decidePass(decidePass), .arpReply(arpReply),
    .igmpAction(igmpAction), .igmpGroup(igmpGroup), .igmpSend(igmpSend), .passRate(passRate));
  // ==========
  // output monitor
  always @(posedge clk) begin
    if (selValid === 4'hf) begin
      chk(selData, exp_byte(fwd));
      fwd = fwd + 1;
    end
    if (selLast === 1'b1) lasts = lasts + 1;
    if (arpReply === 1'b1) arps = arps + 1;
    if (igmpSend === 1'b1) begin
      igs = igs + 1;
      act = igmpAction;
      grp = igmpGroup;
    end
    if (passRate > rmax) rmax = passRate;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  function in_win(input [15:0] p, input [15:0] b);
    integer d;
    begin
      d = (p + 65536 - b) % 65536;
      in_win = d < 2048;
    end
  endfunction
  // byte n of the frame the switch model is sending
  function [7:0] exp_byte(input integer n);
    case (n)
      12: exp_byte = fEt[15:8];
      13: exp_byte = fEt[7:0];
      21: exp_byte = fB21;
      23: exp_byte = fPr;
      34: exp_byte = 8'h00;
      36: exp_byte = fPt[15:8];
      37: exp_byte = fPt[7:0];
      default: exp_byte = n[7:0] ^ 8'h5a;
    endcase
  endfunction
  task frame(input [15:0] pt, input [15:0] et, input [7:0] pr, input [7:0] b21, input [5:0] len);
    reg udp;
    begin
      udp = et == 16'h0800 && pr == 8'h11;
      {fwd, lasts, arps, rmax} = 0;
      {fEt, fPr, fPt, fB21} = {et, pr, pt, b21};
      i_net_switch_model.send(len, et, pr, pt, b21, 8'h00);
      // the rate window must close twice after the drain before the idle check
      repeat (80) @(posedge clk);
      #1;
      chk(fwd, udp && in_win(pt, windowBase) ? len : 0);
      chk(lasts, udp && in_win(pt, windowBase));
      chk(rmax != 0, udp && in_win(pt, windowBase));
      chk(passRate, 0);
      chk(arps, et == 16'h0806 && b21 == 8'h01);
      if (udp) chk(decidePass, in_win(pt, windowBase));
    end
  endtask
  task tbl(input [31:0] addr, input v, input [1:0] expAct, input n, input [9:0] wait_c);
    begin
      {tableWrite, tableIndex, tableAddr, tablePort, tableValid} = {1'b1, 8'h05, addr, 16'd57100, v};
      @(posedge clk);
      #1;
      tableWrite = 1'b0;
      igs = 0;
      if (wait_c > 300) i_net_switch_model.send(42, 16'h0800, 8'h02, 16'h0, 8'h0, 8'h11);
      repeat (wait_c) @(posedge clk);
      #1;
      chk(igs, n);
      if (n) chk(act, expAct);
      if (n) chk(grp, addr);
    end
  endtask
  task end_of_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    mismatches = mismatches + 1;
    end_of_test;
  end
  // ==========
  // scenarios
  initial begin
    {fwd, lasts, arps, igs, rmax} = 0;
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (5) @(posedge clk);
    #1 windowBase = 16'd57000;
    frame(16'd57000, 16'h0800, 8'h11, 8'h0, 38);
    frame(16'd59047, 16'h0800, 8'h11, 8'h0, 40);
    frame(16'd59048, 16'h0800, 8'h11, 8'h0, 38);
    frame(16'd56999, 16'h0800, 8'h11, 8'h0, 39);
    frame(16'd57500, 16'h0800, 8'h06, 8'h0, 41);
    frame(16'd57500, 16'h0806, 8'h00, 8'h01, 42);
    frame(16'd57500, 16'h0806, 8'h00, 8'h02, 42);
    windowBase = 16'hfc00;
    frame(16'h03ff, 16'h0800, 8'h11, 8'h0, 41);
    frame(16'h0400, 16'h0800, 8'h11, 8'h0, 38);
    for (k = 0; k < 20; k = k + 1) begin
      rnd = $random(seed);
      windowBase = rnd[15:0];
      rnd = $random(seed);
      frame(windowBase + {4'h0, rnd[11:0]}, 16'h0800, 8'h11, 8'h0, 6'd38 + {2'b00, rnd[19:16]});
    end
    tbl(32'he0010203, 1'b1, 2'h1, 1'b1, 300);
    tbl(32'he0010203, 1'b0, 2'h2, 1'b1, 300);
    tbl(32'h0a000001, 1'b1, 2'h0, 1'b0, 300);
    tbl(32'he0010204, 1'b1, 2'h1, 1'b1, 300);
    tbl(32'he0010204, 1'b1, 2'h1, 1'b1, 600);
    end_of_test;
  end
endmodule // testbench
